//--- inc/tag_filter_pkg.sv
package tag_filter_pkg;

   // ----------------------------------------------------------------
   // register bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;                    // register address width
   localparam int DATA_W = 8;                    // register data width

   // ----------------------------------------------------------------
   // command offsets: each command is a write, its value is the data
   // ----------------------------------------------------------------
   localparam logic [7:0] LOCK_OFF_CMD_ADDR          = 8'h00; // filter off, reads mode
   localparam logic [7:0] LOCK_UNTIL_OTHER_TAG_ADDR  = 8'h01; // lock_until_other_tag_cmd
   localparam logic [7:0] LOCK_WITH_TIMEOUT_ADDR     = 8'h02; // lock_with_timeout_cmd
   localparam logic [7:0] LOCK_TIMEOUT_ADDR          = 8'h03; // lock_timeout_cmd
   localparam logic [7:0] SKIP_EMPTY_SLOT_ADDR       = 8'h04; // skip_empty_slot_cmd
   localparam logic [7:0] STATUS_ADDR                = 8'h05; // read-only state

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int         STATUS_EXPIRED_BIT  = 7;     // timeout has run out
   localparam int         STATUS_ARMED_BIT    = 6;     // a tag identity is held
   localparam logic [7:0] TIMEOUT_MAX_S       = 8'hB4; // 180 s upper limit
   localparam logic [7:0] TIMEOUT_RESET_S     = 8'h0A; // 10 s after start-up
   localparam logic       SKIP_RESET          = 1'b1;  // skip empty slots by default
   localparam logic [7:0] SECONDS_SATURATE    = 8'hFF; // elapsed counter ceiling

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;             // 100 MHz clock
   localparam int SECOND_NS      = 1_000_000_000;  // one second in ns
   localparam int CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // lock modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_UNTIL_OTHER,
      MODE_TIMEOUT
   } lock_mode_type;

endpackage

//--- core/second_ticker.sv
// one-cycle enable pulse every CYCLES_PER_TICK clocks, restartable so that
// the first second after a restart is a full second
module second_ticker import tag_filter_pkg::*; #(
   parameter int CYCLES_PER_TICK = CYCLES_PER_SEC
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // control
   input  wire logic restart,
   // enable out
   output logic      tick
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (CYCLES_PER_TICK < 2) begin : g_bad_period
      $error("second_ticker needs at least two cycles per tick");
   end

   localparam int CNT_W = $clog2(CYCLES_PER_TICK);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES_PER_TICK - 1);

   typedef struct packed {
      logic [CNT_W-1:0] count;   // cycles into the current second
      logic             tick;    // registered enable pulse
   } ticker_state_type;

   ticker_state_type state_q;    // registered state
   ticker_state_type state_d;    // next state

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d      = state_q;
      state_d.tick = 1'b0;
      if (restart) begin
         // restart wins so a fresh report never sees a stale partial second
         state_d.count = '0;
      end else if (state_q.count == LAST) begin
         state_d.count = '0;
         state_d.tick  = 1'b1;
      end else begin
         state_d.count = state_q.count + CNT_W'(1);
      end
   end

   // state register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign tick = state_q.tick;

endmodule

//--- core/tag_repeat_read_filter.sv
module tag_repeat_read_filter import tag_filter_pkg::*; #(
   parameter int UID_W           = 64,              // transponder identity width
   parameter int CYCLES_PER_SECOND = CYCLES_PER_SEC // shorten for simulation
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [DATA_W-1:0] reg_rdata,
   // tag reads from the air interface
   input  wire logic              tag_valid,
   input  wire logic [UID_W-1:0]  tag_id,
   // filtered reports
   output logic                   report_valid,
   output logic      [UID_W-1:0]  report_id,
   // anticollision slot control
   input  wire logic              slot_empty,
   output logic                   slot_skip,
   output logic                   skip_enable
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (UID_W < 1) begin : g_bad_uid
      $error("tag_repeat_read_filter needs a non-empty identity");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // timeout values above the limit are refused, not clipped
   function automatic logic timeout_ok(input logic [DATA_W-1:0] value);
      timeout_ok = (value <= TIMEOUT_MAX_S);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      lock_mode_type     mode;         // current lock mode
      logic [7:0]        timeout_s;    // lock two timeout in seconds
      logic              skip;         // skip empty slots
      logic              held;         // held identity is meaningful
      logic [UID_W-1:0]  held_id;      // last tag seen
      logic [7:0]        secs;         // seconds since last report
      logic              report_valid; // registered report strobe
      logic [UID_W-1:0]  report_id;    // registered report identity
      logic              slot_skip;    // registered skip pulse
      logic [DATA_W-1:0] rdata;        // read data, one cycle later
      logic              timeout_set;  // software has written a timeout
   } filter_state_type;

   filter_state_type state_q;          // registered state
   filter_state_type state_d;          // next state

   logic same_tag;                     // incoming tag equals the held one
   logic expired;                      // lock two timeout has run out
   logic report_now;                   // the incoming tag is passed on
   logic sec_tick;                     // one pulse per second

   // ----------------------------------------------------------------
   // second timebase, restarted by each report
   // ----------------------------------------------------------------
   second_ticker #(
      .CYCLES_PER_TICK (CYCLES_PER_SECOND)
   ) u_ticker (
      .clk     (clk),
      .reset   (reset),
      .restart (report_now),
      .tick    (sec_tick)
   );

   // ----------------------------------------------------------------
   // filter decision
   // ----------------------------------------------------------------
   assign same_tag = state_q.held && (tag_id == state_q.held_id);
   // the count resets on a report, so timeout 0 re-reports every read
   assign expired  = (state_q.secs >= state_q.timeout_s);

   always_comb begin
      report_now = 1'b0;
      if (tag_valid) begin
         case (state_q.mode)
            MODE_OFF: begin
               report_now = 1'b1;
            end
            MODE_UNTIL_OTHER: begin
               // a repeat is held back until some other tag shows up
               report_now = !same_tag;
            end
            MODE_TIMEOUT: begin
               // a tag lingering in the field stays silent until expiry
               report_now = !same_tag || expired;
            end
            default: begin
               report_now = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d              = state_q;
      state_d.report_valid = 1'b0;
      state_d.slot_skip    = 1'b0;
      state_d.rdata        = '0;

      // elapsed seconds, saturating so a long absence never wraps
      if (report_now) begin
         state_d.secs = '0;
      end else if (sec_tick && (state_q.secs != SECONDS_SATURATE)) begin
         state_d.secs = state_q.secs + 8'h01;
      end

      // every read tag becomes the held one; in lock one any other tag
      // therefore re-arms the previous one
      if (tag_valid) begin
         state_d.held    = 1'b1;
         state_d.held_id = tag_id;
      end
      if (report_now) begin
         state_d.report_valid = 1'b1;
         state_d.report_id    = tag_id;
      end

      // empty slot handling for the anticollision sequencer
      if (slot_empty) begin
         state_d.slot_skip = state_q.skip;
      end

      // command writes: the value travels as write data
      if (reg_write) begin
         case (reg_addr)
            LOCK_OFF_CMD_ADDR: begin
               state_d.mode = MODE_OFF;
               state_d.held = 1'b0;
            end
            LOCK_UNTIL_OTHER_TAG_ADDR: begin
               // a new mode starts with nothing locked
               state_d.mode = MODE_UNTIL_OTHER;
               state_d.held = 1'b0;
            end
            LOCK_WITH_TIMEOUT_ADDR: begin
               state_d.mode = MODE_TIMEOUT;
               state_d.held = 1'b0;
            end
            LOCK_TIMEOUT_ADDR: begin
               if (timeout_ok(reg_wdata)) begin
                  state_d.timeout_s   = reg_wdata;
                  state_d.timeout_set = 1'b1;
               end
            end
            SKIP_EMPTY_SLOT_ADDR: begin
               // only the low bit carries meaning
               state_d.skip = reg_wdata[0];
            end
            default: begin
               // unmapped and read-only offsets ignore writes
            end
         endcase
      end

      // reads answer in the next cycle; unmapped offsets read zero
      if (reg_read) begin
         case (reg_addr)
            LOCK_OFF_CMD_ADDR: begin
               state_d.rdata = {6'h00, state_q.mode};
            end
            LOCK_TIMEOUT_ADDR: begin
               state_d.rdata = state_q.timeout_s;
            end
            SKIP_EMPTY_SLOT_ADDR: begin
               state_d.rdata = {7'h00, state_q.skip};
            end
            STATUS_ADDR: begin
               state_d.rdata                     = {6'h00, state_q.mode};
               state_d.rdata[STATUS_EXPIRED_BIT] = expired;
               state_d.rdata[STATUS_ARMED_BIT]   = state_q.held;
            end
            default: begin
               state_d.rdata = '0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q           <= '0;
         state_q.mode      <= MODE_OFF;
         state_q.timeout_s <= TIMEOUT_RESET_S;
         state_q.skip      <= SKIP_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata    = state_q.rdata;
   assign report_valid = state_q.report_valid;
   assign report_id    = state_q.report_id;
   assign slot_skip    = state_q.slot_skip;
   assign skip_enable  = state_q.skip;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_lock1_no_repeat: assert property (@(posedge clk) disable iff (reset)
      (state_q.mode == MODE_UNTIL_OTHER) && tag_valid && same_tag && !reg_write
      |=> !report_valid)
      else $error("repeated tag reported in lock one");

   a_lock1_new_tag: assert property (@(posedge clk) disable iff (reset)
      (state_q.mode == MODE_UNTIL_OTHER) && tag_valid && !same_tag
      |=> report_valid && (report_id == $past(tag_id)))
      else $error("different tag not reported in lock one");

   a_lock2_hold: assert property (@(posedge clk) disable iff (reset)
      (state_q.mode == MODE_TIMEOUT) && tag_valid && same_tag && !expired
      |=> !report_valid)
      else $error("lingering tag reported before timeout");

   a_timeout_range: assert property (@(posedge clk) disable iff (reset)
      state_q.timeout_s <= TIMEOUT_MAX_S)
      else $error("timeout outside 0 to 180 seconds");

   a_timeout_default: assert property (@(posedge clk) disable iff (reset)
      !state_q.timeout_set |-> (state_q.timeout_s == TIMEOUT_RESET_S))
      else $error("timeout moved from default without a write");

   a_skip_off: assert property (@(posedge clk) disable iff (reset)
      slot_empty && !skip_enable && !(reg_write && (reg_addr == SKIP_EMPTY_SLOT_ADDR))
      |=> !slot_skip ##1 !slot_skip || !$past(slot_empty))
      else $error("empty slot skipped while skipping is off");

   a_skip_on: assert property (@(posedge clk) disable iff (reset)
      slot_empty && skip_enable |=> slot_skip)
      else $error("empty slot not skipped while skipping is on");

   a_timeout_cmd: assert property (@(posedge clk) disable iff (reset)
      reg_write && (reg_addr == LOCK_TIMEOUT_ADDR)
      |=> (state_q.timeout_s == ($past(timeout_ok(reg_wdata)) ?
          $past(reg_wdata) : $past(state_q.timeout_s))))
      else $error("timeout command value not taken");

   a_lock2_rearm: assert property (@(posedge clk) disable iff (reset)
      (state_q.mode == MODE_TIMEOUT) && tag_valid && same_tag && expired
      |=> report_valid ##1 (state_q.secs == 8'h00 || sec_tick || $past(sec_tick)))
      else $error("tag not re-reported after timeout");

   c_lock1_suppress: cover property (@(posedge clk) disable iff (reset)
      (state_q.mode == MODE_UNTIL_OTHER) && tag_valid && same_tag);

   c_lock2_rearm: cover property (@(posedge clk) disable iff (reset)
      (state_q.mode == MODE_TIMEOUT) && tag_valid && same_tag && expired);

   c_slot_skipped: cover property (@(posedge clk) disable iff (reset)
      slot_empty ##1 slot_skip);

   c_mode_off_pass: cover property (@(posedge clk) disable iff (reset)
      (state_q.mode == MODE_OFF) && tag_valid ##1 report_valid);

   // ----------------------------------------------------------------
   // output pulse shape
   // ----------------------------------------------------------------
   // read data must fall back to zero so a stale value is never mistaken
   // for a fresh answer by a host that samples late
   a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
      !reg_read |=> (reg_rdata == '0))
      else $error("read data standing without a read");

   a_report_cause: assert property (@(posedge clk) disable iff (reset)
      report_valid |-> $past(tag_valid))
      else $error("report without a tag read");

   a_skip_pulse: assert property (@(posedge clk) disable iff (reset)
      !slot_empty |=> !slot_skip)
      else $error("slot skipped without an empty slot");

   // offsets 0x00 to 0x02 are the three mode commands
   a_mode_clear: assert property (@(posedge clk) disable iff (reset)
      reg_write && (reg_addr <= LOCK_WITH_TIMEOUT_ADDR) |=> !state_q.held)
      else $error("mode command left an identity held");

endmodule

//--- tb/host_model.sv
// host side: issues one command per register write, reads back settings
module host_model import tag_filter_pkg::*; (
   // clock
   input  wire logic              clk,
   // command port toward the filter
   output logic      [ADDR_W-1:0] reg_addr,
   output logic      [DATA_W-1:0] reg_wdata,
   output logic                   reg_write,
   output logic                   reg_read
);
   timeunit 1ns;
   timeprecision 1ps;

   // -----------------------------------------------------------
   // idle port
   // -----------------------------------------------------------
   initial begin
      reg_addr  = '0;
      reg_wdata = '0;
      reg_write = 1'b0;
      reg_read  = 1'b0;
   end

   // command code on the address, its value beside it
   // timeout values stay within 0..180 unless a refusal is wanted
   task automatic send(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      // released data must not keep looking valid
      reg_wdata <= ~d;
      reg_addr  <= ~a;
   endtask

   // read strobe for one cycle; data is judged by the bench monitor
   task automatic fetch(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      reg_addr <= ~a;
   endtask
endmodule

//--- tb/tag_repeat_read_filter_test.sv
module tag_repeat_read_filter_test;
   import tag_filter_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int CPS = 20;        // short second keeps the run brief

   logic              clk;
   logic              reset;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_write;
   logic              reg_read;
   logic [DATA_W-1:0] reg_rdata;
   logic              tag_valid;
   logic [63:0]       tag_id;
   logic              report_valid;
   logic [63:0]       report_id;
   logic              slot_empty;
   logic              slot_skip;
   logic              skip_enable;
   int                err_total;
   int                checks_done;
   int                seed;
   logic [63:0]       id_a;
   logic [63:0]       id_b;
   logic [63:0]       rep_q[$];   // expected reports in order
   logic [7:0]        rd_q[$];    // expected read data
   logic              sk_q[$];    // expected skip answers
   logic              rd_p;       // read strobe seen last cycle
   logic              se_p;       // empty slot seen last cycle

   tag_repeat_read_filter #(.UID_W(64), .CYCLES_PER_SECOND(CPS)) uut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .tag_valid(tag_valid), .tag_id(tag_id), .report_valid(report_valid),
      .report_id(report_id), .slot_empty(slot_empty), .slot_skip(slot_skip),
      .skip_enable(skip_enable));

   host_model hst (
      .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read));

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s seen %h exp %h", $time, m, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks_done %0d err_total %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      hst.fetch(a);
   endtask

   // one tag read; e says whether it should pass the filter
   task automatic tag(input logic [63:0] id, input logic e);
      @(posedge clk);
      tag_valid <= 1'b1;
      tag_id    <= id;
      if (e) begin
         rep_q.push_back(id);
      end
      @(posedge clk);
      tag_valid <= 1'b0;
      tag_id    <= ~id;
   endtask

   task automatic slot(input logic e);
      @(posedge clk);
      slot_empty <= 1'b1;
      sk_q.push_back(e);
      @(posedge clk);
      slot_empty <= 1'b0;
   endtask

   // -----------------------------------------------------------
   // clock and hang guard
   // -----------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("MISMATCH %0t run did not finish", $time);
      final_report();
   end

   // monitor: outputs are settled at the falling edge
   always @(negedge clk) begin
      if (rd_p) begin
         chk(reg_rdata, rd_q.pop_front(), "read data");
      end
      if (se_p) begin
         chk(slot_skip, sk_q.pop_front(), "slot skip");
      end
      if (report_valid === 1'b1) begin
         if (rep_q.size() == 0) begin
            chk(1'b1, 1'b0, "unexpected report");
         end else begin
            chk(report_id, rep_q.pop_front(), "report id");
         end
      end
      rd_p = reg_read;
      se_p = slot_empty;
   end

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      err_total   = 0;
      checks_done = 0;
      seed        = 43883;
      reset       = 1'b1;
      tag_valid   = 1'b0;
      tag_id      = '0;
      slot_empty  = 1'b0;
      rd_p        = 1'b0;
      se_p        = 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      id_a = {$random(seed), $random(seed)};
      id_b = ~id_a;
      @(posedge clk);
      chk(skip_enable, 1'b1, "skip default");
      rd(LOCK_TIMEOUT_ADDR, TIMEOUT_RESET_S);
      rd(SKIP_EMPTY_SLOT_ADDR, 8'h01);
      slot(1'b1);
      hst.send(SKIP_EMPTY_SLOT_ADDR, 8'h00);
      slot(1'b0);
      chk(skip_enable, 1'b0, "skip off");
      hst.send(SKIP_EMPTY_SLOT_ADDR, 8'h01);
      slot(1'b1);
      hst.send(LOCK_TIMEOUT_ADDR, TIMEOUT_MAX_S);
      rd(LOCK_TIMEOUT_ADDR, 8'hB4);
      hst.send(LOCK_TIMEOUT_ADDR, 8'hB5);
      rd(LOCK_TIMEOUT_ADDR, 8'hB4);
      rd(8'h7F, 8'h00);
      // filter off: random tags all pass
      for (int i = 0; i < 3; i++) begin
         tag({$random(seed), $random(seed)}, 1'b1);
      end
      // lock until another tag is read
      hst.send(LOCK_UNTIL_OTHER_TAG_ADDR, 8'h00);
      rd(LOCK_OFF_CMD_ADDR, 8'h01);
      tag(id_a, 1'b1);
      tag(id_a, 1'b0);
      tag(id_a, 1'b0);
      tag(id_b, 1'b1);
      tag(id_a, 1'b1);
      tag(id_a, 1'b0);
      // lock with a two second timeout
      hst.send(LOCK_TIMEOUT_ADDR, 8'h02);
      hst.send(LOCK_WITH_TIMEOUT_ADDR, 8'h00);
      tag(id_a, 1'b1);
      tag(id_a, 1'b0);
      rd(STATUS_ADDR, 8'h42);
      repeat (CPS) @(posedge clk);
      tag(id_a, 1'b0);
      repeat (3 * CPS) @(posedge clk);
      rd(STATUS_ADDR, 8'hC2);
      tag(id_a, 1'b1);
      tag(id_b, 1'b1);
      // zero timeout: every read passes
      hst.send(LOCK_TIMEOUT_ADDR, 8'h00);
      rd(LOCK_TIMEOUT_ADDR, 8'h00);
      tag(id_b, 1'b1);
      // back to filter off: held identity dropped, repeats pass again
      hst.send(LOCK_OFF_CMD_ADDR, 8'h00);
      rd(STATUS_ADDR, 8'h80);
      tag(id_b, 1'b1);
      tag(id_b, 1'b1);
      rd(LOCK_OFF_CMD_ADDR, 8'h00);
      repeat (5) @(posedge clk);
      chk(rep_q.size(), 0, "reports missing");
      chk(rd_q.size() + sk_q.size(), 0, "answers missing");
      final_report();
   end
endmodule
